/* hw/imadd_pkg.sv */
package imadd_pkg;

  // Datapath widths.
  localparam int unsigned Y_W = 15;
  localparam int unsigned K_W = 12;
  localparam int unsigned SHIFT_W = 6;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned RPT_W = 12;
  localparam int unsigned IR_W = 18;
  localparam int unsigned ADDR_W = 8;

  // Field positions: index select in the held instruction word, step code in index seven.
  localparam int unsigned STEP_LSB = 12;
  localparam int unsigned SEL_LSB = 15;

  // Register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_IR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_HOLD = 8'h0C;
  localparam logic [7:0] REG_IDX_BASE = 8'h20;

  // Status register bits.
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_DONE = 1;
  localparam int unsigned STAT_CARRY = 2;
  localparam int unsigned STAT_ZERO = 3;

  // Reset values and fixed operands.
  localparam logic [14:0] Y_ZERO = 15'h0000;
  localparam logic [14:0] Y_ONES = 15'h7FFF;
  localparam logic [11:0] RPT_ZERO = 12'h000;
  localparam logic [11:0] RPT_ONE = 12'h001;
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_RPT = 3'h7;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ADD_INDEX = 3'h1,
    CMD_WRITE_INDEX = 3'h2,
    CMD_REPEAT = 3'h3,
    CMD_COMPLEMENT = 3'h4,
    CMD_COMPARE = 3'h5,
    CMD_ADVANCE = 3'h6
  } imadd_cmd_t;

  // Odd step codes move the address; bit 2 picks the direction.
  function automatic logic step_inc(input logic [2:0] m);
    return m[0] & ~m[2];
  endfunction

  function automatic logic step_dec(input logic [2:0] m);
    return m[0] & m[2];
  endfunction

endpackage

/* hw/imadd_add_if.sv */
`timescale 1ns/1ps
interface imadd_add_if;
  logic [14:0] a;
  logic [14:0] b;
  logic carry_en;
  logic carry_in;
  logic [14:0] sum;
  logic carry_out;

  modport user (
    output a,
    output b,
    output carry_en,
    output carry_in,
    input sum,
    input carry_out
  );

  modport adder (
    input a,
    input b,
    input carry_en,
    input carry_in,
    output sum,
    output carry_out
  );
endinterface

/* hw/imadd_adder.sv */
`timescale 1ns/1ps
module imadd_adder (
  // Operand and result bundle
  imadd_add_if.adder bus
);

  logic [imadd_pkg::Y_W:0] carry;

  // Toggle where the index bit is one, then let each carry toggle the
  // next stage until a zero stage absorbs it.
  always_comb begin
    carry[0] = bus.carry_in;
    for (int i = 0; i < int'(imadd_pkg::Y_W); i++) begin
      bus.sum[i] = bus.a[i] ^ bus.b[i] ^ carry[i];
      carry[i + 1] = bus.carry_en &
        ((bus.a[i] & bus.b[i]) | ((bus.a[i] ^ bus.b[i]) & carry[i]));
    end
  end

  // The end carry is reported but never fed back into any stage.
  assign bus.carry_out = carry[imadd_pkg::Y_W];

endmodule

/* hw/imadd_top.sv */
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - Low twelve bits give the memory address.
// - Base field gives the jump target address.
// - Low six bits give the shift count.
// - Index adds to modifier and base fields.
// - Base section cleared before each new load.
// - Seven fifteen-bit index registers.
// - Index seven: counter low, step modifier high.
// - Selected index cleared, then loaded from buffer.
// - Adder result reaches only the selected index.
// - Repeat decrements counter; zero raises repeat done.
// - Step code: even none, 1/3 up, 5/7 down.
// - Hold buffer captures selected index for adder.
// - Two's complement add on the low fifteen bits.
// - Adder supports compare against an index.
// - Toggle bits, then ripple carries to a zero.
// - Carry out of bit fifteen is never fed back; an add keeps it as a status bit.
// - Add order: load buffer, apply, then carries.
// - Increment injects one into the lowest stage.
// - Decrement adds all ones, end carry dropped.
// - Complement adds all ones without carries.
// - Adder advances the storage address.
// - Compare inverts, adds one, then adds index.
module imadd_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath results
  output logic [11:0] mem_addr,
  output logic [11:0] jump_addr,
  output logic [5:0] shift_count,
  output logic repeat_done,
  output logic busy
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_IR_CLEAR,
    ST_IR_LOAD,
    ST_HOLD_LOAD,
    ST_CMP_INVERT,
    ST_CMP_ONE,
    ST_ADD_APPLY,
    ST_WB_CAPTURE,
    ST_IDX_CLEAR,
    ST_IDX_LOAD,
    ST_RPT_COUNT,
    ST_RPT_STEP,
    ST_COMPL,
    ST_ADVANCE
  } imadd_state_t;

  imadd_state_t state;
  imadd_pkg::imadd_cmd_t cmd;
  logic [14:0] y;
  logic [2:0] sel;
  logic [14:0] hold;
  logic [14:0] wbuf;
  logic [14:0] idx [1:7];
  logic [17:0] ir_pend;
  logic done_flag;
  logic carry_flag;
  logic [31:0] rd_data;
  logic bad_access;
  logic is_idx;
  logic [2:0] idx_num;
  logic wr_go;
  logic [11:0] rpt_cnt;
  logic [2:0] rpt_step;

  imadd_add_if add_bus ();

  imadd_adder u_adder (
    .bus(add_bus)
  );

  function automatic logic [14:0] idx_read(input logic [2:0] s);
    return (s == imadd_pkg::SEL_NONE) ? imadd_pkg::Y_ZERO : idx[s];
  endfunction

  assign rpt_cnt = idx[imadd_pkg::SEL_RPT][imadd_pkg::RPT_W-1:0];
  assign rpt_step = idx[imadd_pkg::SEL_RPT][imadd_pkg::Y_W-1:
    imadd_pkg::STEP_LSB];

  // Adder operand steering. One state per clock, so the ripple always
  // settles before the result is stored.
  always_comb begin
    add_bus.a = y;
    add_bus.b = imadd_pkg::Y_ZERO;
    add_bus.carry_en = 1'b1;
    add_bus.carry_in = 1'b0;
    unique case (state)
      ST_ADD_APPLY: begin
        add_bus.b = hold;
      end
      ST_CMP_INVERT, ST_COMPL: begin
        add_bus.b = imadd_pkg::Y_ONES;
        add_bus.carry_en = 1'b0;
      end
      ST_CMP_ONE, ST_ADVANCE: begin
        add_bus.carry_in = 1'b1;
      end
      ST_RPT_STEP: begin
        if (imadd_pkg::step_inc(rpt_step)) begin
          add_bus.carry_in = 1'b1;
        end else if (imadd_pkg::step_dec(rpt_step)) begin
          add_bus.b = imadd_pkg::Y_ONES;
        end
      end
      default: begin
      end
    endcase
  end

  // APB decode.
  assign is_idx = (paddr[7:5] == imadd_pkg::REG_IDX_BASE[7:5]) &&
    (paddr[1:0] == 2'h0);
  assign idx_num = paddr[4:2];
  assign wr_go = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    rd_data = 32'h0000_0000;
    bad_access = 1'b0;
    if (is_idx) begin
      rd_data = {17'h00000, idx_read(idx_num)};
      bad_access = pwrite && (state != ST_IDLE);
    end else begin
      unique case (paddr)
        imadd_pkg::REG_CMD: begin
          rd_data = {29'h0000_0000, cmd};
          bad_access = pwrite && (state != ST_IDLE);
        end
        imadd_pkg::REG_IR: begin
          rd_data = {14'h0000, sel, y};
          bad_access = pwrite && (state != ST_IDLE);
        end
        imadd_pkg::REG_STAT: begin
          rd_data[imadd_pkg::STAT_BUSY] = (state != ST_IDLE);
          rd_data[imadd_pkg::STAT_DONE] = done_flag;
          rd_data[imadd_pkg::STAT_CARRY] = carry_flag;
          rd_data[imadd_pkg::STAT_ZERO] = (y == imadd_pkg::Y_ZERO);
        end
        imadd_pkg::REG_HOLD: begin
          rd_data = {17'h00000, hold};
        end
        default: begin
          bad_access = 1'b1;
        end
      endcase
    end
  end

  // One wait state: the answer is registered in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= bad_access;
      end
    end
  end

  // Sequencer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cmd <= imadd_pkg::CMD_NONE;
      ir_pend <= 18'h00000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (wr_go && !is_idx && paddr == imadd_pkg::REG_IR) begin
            ir_pend <= pwdata[imadd_pkg::IR_W-1:0];
            state <= ST_IR_CLEAR;
          end else if (wr_go && !is_idx && paddr == imadd_pkg::REG_CMD) begin
            cmd <= imadd_pkg::imadd_cmd_t'(pwdata[2:0]);
            unique case (pwdata[2:0])
              imadd_pkg::CMD_ADD_INDEX: state <= ST_HOLD_LOAD;
              imadd_pkg::CMD_COMPARE: state <= ST_HOLD_LOAD;
              imadd_pkg::CMD_WRITE_INDEX: state <= ST_WB_CAPTURE;
              imadd_pkg::CMD_REPEAT: state <= ST_RPT_COUNT;
              imadd_pkg::CMD_COMPLEMENT: state <= ST_COMPL;
              imadd_pkg::CMD_ADVANCE: state <= ST_ADVANCE;
              default: state <= ST_IDLE;
            endcase
          end
        end
        ST_IR_CLEAR: state <= ST_IR_LOAD;
        ST_HOLD_LOAD: begin
          state <= (cmd == imadd_pkg::CMD_COMPARE) ? ST_CMP_INVERT :
            ST_ADD_APPLY;
        end
        ST_CMP_INVERT: state <= ST_CMP_ONE;
        ST_CMP_ONE: state <= ST_ADD_APPLY;
        ST_WB_CAPTURE: state <= ST_IDX_CLEAR;
        ST_IDX_CLEAR: state <= ST_IDX_LOAD;
        ST_RPT_COUNT: state <= ST_RPT_STEP;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Instruction word: modifier and base fields plus index select.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      y <= imadd_pkg::Y_ZERO;
      sel <= imadd_pkg::SEL_NONE;
      carry_flag <= 1'b0;
    end else begin
      unique case (state)
        ST_IR_CLEAR: begin
          y <= imadd_pkg::Y_ZERO;
          sel <= imadd_pkg::SEL_NONE;
        end
        ST_IR_LOAD: begin
          y <= ir_pend[imadd_pkg::Y_W-1:0];
          sel <= ir_pend[imadd_pkg::IR_W-1:imadd_pkg::SEL_LSB];
        end
        ST_ADD_APPLY: begin
          y <= add_bus.sum;
          carry_flag <= add_bus.carry_out;
        end
        ST_CMP_INVERT, ST_CMP_ONE, ST_COMPL, ST_ADVANCE, ST_RPT_STEP: begin
          y <= add_bus.sum;
        end
        default: begin
        end
      endcase
    end
  end

  // Index hold buffer and index write buffer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold <= imadd_pkg::Y_ZERO;
      wbuf <= imadd_pkg::Y_ZERO;
    end else begin
      if (state == ST_HOLD_LOAD) begin
        hold <= idx_read(sel);
      end
      if (state == ST_WB_CAPTURE) begin
        wbuf <= add_bus.sum;
      end
    end
  end

  // Index registers. Software may preload them only while idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 1; i <= 7; i++) begin
        idx[i] <= imadd_pkg::Y_ZERO;
      end
    end else begin
      if (wr_go && is_idx && idx_num != imadd_pkg::SEL_NONE) begin
        idx[idx_num] <= pwdata[imadd_pkg::Y_W-1:0];
      end
      if (state == ST_IDX_CLEAR && sel != imadd_pkg::SEL_NONE) begin
        idx[sel] <= imadd_pkg::Y_ZERO;
      end
      if (state == ST_IDX_LOAD && sel != imadd_pkg::SEL_NONE) begin
        idx[sel] <= wbuf;
      end
      if (state == ST_RPT_COUNT && rpt_cnt != imadd_pkg::RPT_ZERO) begin
        idx[imadd_pkg::SEL_RPT][imadd_pkg::RPT_W-1:0] <=
          rpt_cnt - imadd_pkg::RPT_ONE;
      end
    end
  end

  // Repeat completion: a pulse and a sticky status bit. A new completion
  // wins over a clear written in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      repeat_done <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      repeat_done <= (state == ST_RPT_COUNT) &&
        (rpt_cnt <= imadd_pkg::RPT_ONE);
      if ((state == ST_RPT_COUNT) && (rpt_cnt <= imadd_pkg::RPT_ONE)) begin
        done_flag <= 1'b1;
      end else if (wr_go && !is_idx && paddr == imadd_pkg::REG_STAT &&
                   pwdata[imadd_pkg::STAT_DONE]) begin
        done_flag <= 1'b0;
      end
    end
  end

  // Address views trail the instruction word by one clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= 12'h000;
      jump_addr <= 12'h000;
      shift_count <= 6'h00;
      busy <= 1'b0;
    end else begin
      mem_addr <= y[imadd_pkg::K_W-1:0];
      jump_addr <= y[imadd_pkg::K_W-1:0];
      shift_count <= y[imadd_pkg::SHIFT_W-1:0];
      busy <= (state != ST_IDLE);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  add_ripple_a: assert property (
    add_bus.carry_en |-> add_bus.sum ==
      15'(add_bus.a + add_bus.b + 15'(add_bus.carry_in)))
    else $error("adder sum wrong");
  end_carry_a: assert property (
    add_bus.carry_en |-> add_bus.carry_out ==
      (({1'b0, add_bus.a} + {1'b0, add_bus.b} + 16'(add_bus.carry_in))
       >> imadd_pkg::Y_W))
    else $error("end carry wrong");
  compl_nocarry_a: assert property (
    state == ST_COMPL |=> y == ~$past(y))
    else $error("complement wrong");
  ir_clear_a: assert property (
    state == ST_IR_CLEAR |=> y == imadd_pkg::Y_ZERO ##1
      y == $past(ir_pend[14:0], 2))
    else $error("word not cleared before load");
  idx_clear_load_a: assert property (
    state == ST_IDX_CLEAR && sel == 3'h3 |=> idx[3] == 15'h0000 ##1
      idx[3] == $past(wbuf))
    else $error("index clear then load broken");
  hold_capture_a: assert property (
    state == ST_HOLD_LOAD |=> hold == $past(idx_read(sel)))
    else $error("hold buffer wrong");
  rpt_count_a: assert property (
    state == ST_RPT_COUNT && rpt_cnt == 12'h001 |=>
      repeat_done && rpt_cnt == 12'h000)
    else $error("repeat count wrong");
  rpt_step_a: assert property (
    state == ST_RPT_STEP && !rpt_step[0] |=> y == $past(y))
    else $error("even step changed word");
  rpt_dec_a: assert property (
    state == ST_RPT_STEP && rpt_step == 3'h5 |=> y == 15'($past(y) - 1))
    else $error("decrement wrong");
  compare_a: assert property (
    state == ST_CMP_INVERT |=> ##2 y == 15'($past(hold, 3) - $past(y, 3)))
    else $error("compare result wrong");
  addr_view_a: assert property (
    ##1 mem_addr == $past(y[11:0]) && shift_count == $past(y[5:0]))
    else $error("address view wrong");

  cov_add_c: cover property (state == ST_HOLD_LOAD ##1 state == ST_ADD_APPLY);
  cov_cmp_c: cover property (state == ST_CMP_ONE);
  cov_done_c: cover property (repeat_done);
  cov_wb_c: cover property (state == ST_IDX_LOAD && sel == 3'h7);

endmodule

/* dv/imadd_apb_master.sv */
`timescale 1ns/1ps
// Sequencer stand-in: one APB request at a time, held until pready.
module imadd_apb_master (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB requester side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a stale word is never mistaken for live.
    pwdata <= ~d;
  endtask
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic pclk;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, repeat_done, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [11:0] mem_addr, jump_addr;
  logic [5:0] shift_count;
  logic rerr;
  logic [14:0] y, y2;
  logic [15:0] s16;
  logic [14:0] idx [1:7];
  logic [2:0] m;
  int n_errors = 0;
  int check_count = 0;
  int n_done = 0;
  int d0;

  imadd_top i_imadd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .jump_addr(jump_addr),
    .shift_count(shift_count), .repeat_done(repeat_done), .busy(busy));

  imadd_apb_master i_imadd_apb_master (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (repeat_done === 1'b1) n_done <= n_done + 1;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    i_imadd_apb_master.xfer(1'b1, a, d, rdat, rerr);
  endtask

  task rd(input logic [7:0] a);
    i_imadd_apb_master.xfer(1'b0, a, 32'h00000000, rdat, rerr);
  endtask

  // Polls status up to 40 more times; a block that never goes idle fails the checks below.
  task idle();
    int i;
    i = 0;
    rd(imadd_pkg::REG_STAT);
    while (rdat[imadd_pkg::STAT_BUSY] !== 1'b0 && i < 40) begin
      rd(imadd_pkg::REG_STAT);
      i++;
    end
    // A block still busy after the poll limit counts as a mismatch here.
    chk({31'h0, rdat[imadd_pkg::STAT_BUSY]}, 32'h00000000);
    chk({31'h0, busy}, 32'h00000000);
  endtask

  task cmd(input logic [2:0] c);
    wr(imadd_pkg::REG_CMD, {29'h0, c});
    chk({31'h0, rerr}, 32'h00000000);
    // The busy pin trails the sequencer by one clock.
    @(negedge pclk);
    @(negedge pclk);
    chk({31'h0, busy}, 32'h00000001);
    idle();
  endtask

  task set_ir(input logic [2:0] s, input logic [14:0] v);
    wr(imadd_pkg::REG_IR, {14'h0, s, v});
    idle();
  endtask

  task chk_y(input logic [14:0] e);
    rd(imadd_pkg::REG_IR);
    chk({17'h0, rdat[14:0]}, {17'h0, e});
    chk({20'h0, mem_addr}, {20'h0, e[11:0]});
    chk({20'h0, jump_addr}, {20'h0, e[11:0]});
    chk({26'h0, shift_count}, {26'h0, e[5:0]});
  endtask

  function automatic logic [14:0] stepped(logic [14:0] v, logic [2:0] s);
    if (s[0] == 1'b0) return v;
    return s[2] ? v + 15'h7FFF : v + 15'h0001;
  endfunction

  task finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    void'($urandom(32'h6a80b48c));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk({20'h0, mem_addr}, 32'h00000000);
    for (int n = 1; n < 8; n++) begin
      rd(imadd_pkg::REG_IDX_BASE + 8'(4 * n));
      chk(rdat, 32'h00000000);
    end
    rd(8'h40);
    chk({31'h0, rerr}, 32'h00000001);
    chk(rdat, 32'h00000000);
    $display("test reset_and_map done");

    for (int n = 1; n < 8; n++) begin
      idx[n] = (n == 1) ? 15'h7FFF : 15'($urandom);
      set_ir(3'(n), idx[n]);
      cmd(imadd_pkg::CMD_WRITE_INDEX);
    end
    // Reading every slot afterwards shows each write hit its target and no slot written before it.
    for (int n = 1; n < 8; n++) begin
      rd(imadd_pkg::REG_IDX_BASE + 8'(4 * n));
      chk(rdat, {17'h0, idx[n]});
    end
    $display("test index_write done");

    for (int n = 1; n < 8; n++) begin
      y = (n == 2) ? 15'h7FFF : 15'($urandom);
      set_ir(3'(n), y);
      cmd(imadd_pkg::CMD_ADD_INDEX);
      chk_y(y + idx[n]);
      s16 = {1'b0, y} + {1'b0, idx[n]};
      rd(imadd_pkg::REG_STAT);
      chk({31'h0, rdat[imadd_pkg::STAT_CARRY]}, {31'h0, s16[15]});
      rd(imadd_pkg::REG_HOLD);
      chk(rdat, {17'h0, idx[n]});
      y = y + idx[n];
      cmd(imadd_pkg::CMD_COMPLEMENT);
      chk_y(~y);
      y2 = ~y + 15'h0001;
      cmd(imadd_pkg::CMD_ADVANCE);
      chk_y(y2);
      cmd(imadd_pkg::CMD_COMPARE);
      chk_y(idx[n] - y2);
    end
    $display("test arithmetic done");

    for (int k = 0; k < 8; k++) begin
      m = 3'(k);
      set_ir(3'h7, {m, 12'h002});
      cmd(imadd_pkg::CMD_WRITE_INDEX);
      y = 15'($urandom);
      set_ir(3'h7, y);
      d0 = n_done;
      wr(imadd_pkg::REG_STAT, 32'h00000002);
      cmd(imadd_pkg::CMD_REPEAT);
      chk(32'(n_done - d0), 32'h00000000);
      rd(imadd_pkg::REG_STAT);
      chk({31'h0, rdat[imadd_pkg::STAT_DONE]}, 32'h00000000);
      rd(imadd_pkg::REG_IDX_BASE + 8'h1C);
      chk(rdat, {17'h0, m, 12'h001});
      chk_y(stepped(y, m));
      cmd(imadd_pkg::CMD_REPEAT);
      chk(32'(n_done - d0), 32'h00000001);
      chk_y(stepped(stepped(y, m), m));
      rd(imadd_pkg::REG_STAT);
      chk({31'h0, rdat[imadd_pkg::STAT_DONE]}, 32'h00000001);
      rd(imadd_pkg::REG_IDX_BASE + 8'h1C);
      chk(rdat, {17'h0, m, 12'h000});
    end
    $display("test repeat done");
    finish_test();
  end
endmodule
